// ===== dv/ppc_pad_model.sv
// pad cell model: pin level seen through the pull devices
`timescale 1ns/100ps
module ppc_pad_model
(
  input  wire logic       clk_in,
  input  wire logic [7:0] pull_on_in,
  input  wire logic [7:0] pull_down_in,
  output logic      [7:0] pin_out
);
  logic [7:0] float_ff = 8'h55;
  // unpulled pins wander so a stale level never passes for a pull
  always @(posedge clk_in)
    float_ff <= ~float_ff;
  assign pin_out = (pull_on_in & ~pull_down_in) | (~pull_on_in & float_ff);
endmodule

// ===== dv/ppc_properties.sv
// port pad control checker
`timescale 1ns/100ps
module ppc_properties
(
  input wire logic        clk_in, srst_in, avs_read_in, avs_write_in, avs_waitrequest_out,
  input wire logic [31:0] avs_readdata_out,
  input wire logic [7:0]  port_b_direction_in, port_b_periph_oe_in, port_b_analog_in,
  input wire logic [7:0]  port_b_pull_on_out, port_b_pull_down_out, port_b_slew_on_out,
  input wire logic [7:0]  port_b_drive_high_out,
  input wire logic [3:0]  port_c_direction_in, port_c_periph_oe_in, port_c_analog_in,
  input wire logic [3:0]  port_c_pull_on_out, port_c_pull_down_out, port_c_slew_on_out,
  input wire logic [3:0]  port_c_drive_high_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  wire logic [11:0] pull_w  = {port_c_pull_on_out, port_b_pull_on_out};
  wire logic [11:0] down_w  = {port_c_pull_down_out, port_b_pull_down_out};
  wire logic [11:0] slew_w  = {port_c_slew_on_out, port_b_slew_on_out};
  wire logic [11:0] drive_w = {port_c_drive_high_out, port_b_drive_high_out};
  logic [11:0] out_ff;
  logic [11:0] ana_ff;
  logic [2:0]  idle_ff;
  // pad outputs lag their inputs one cycle, so compare against last cycle
  always_ff @(posedge clk_in)
  begin
    out_ff <= {port_c_direction_in | port_c_periph_oe_in, port_b_direction_in | port_b_periph_oe_in};
    ana_ff <= {port_c_analog_in, port_b_analog_in};
    if (srst_in || avs_write_in)
      idle_ff <= 3'h0;
    else if (idle_ff != 3'h7)
      idle_ff <= idle_ff + 3'h1;
  end
  pull_out_a: assert property
    (~|(pull_w & out_ff)) else $error("pull on while output");
  pull_ana_a: assert property
    (~|(pull_w & ana_ff)) else $error("pull on under analog");
  pull_down_a: assert property
    (~|(down_w & ~pull_w)) else $error("pull down without pull");
  slew_in_a: assert property
    (~|(slew_w & ~out_ff)) else $error("slew on input pin");
  reset_clear_a: assert property
    ($fell(srst_in) |-> avs_waitrequest_out && ~|{pull_w, slew_w, drive_w}) else $error("reset");
  read_high_a: assert property
    (avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0) else $error("rd");
  drive_hold_a: assert property
    (idle_ff > 3'h3 |-> $stable(drive_w)) else $error("drive moved without write");
  pull_hold_a: assert property
    (idle_ff > 3'h3 && $stable(out_ff) && $stable(ana_ff) |-> $stable(pull_w)) else $error("pull");
  cover property (|down_w);
  cover property (|slew_w);
  cover property (avs_write_in && !avs_waitrequest_out);
endmodule

// ===== dv/tb.sv
// self-checking bench for the port pad control block
`timescale 1ns/100ps
module tb;
  logic        clk_in = 1'b0, srst_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic        snap = 1'b0, avs_waitrequest_out;
  logic [3:0]  avs_address_in = 4'h0, avs_byteenable_in = 4'h0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
  logic [7:0]  port_b_direction_in = 8'h0, port_b_periph_oe_in = 8'h0, port_b_analog_in = 8'h0;
  logic [3:0]  port_c_direction_in = 4'h0, port_c_periph_oe_in = 4'h0, port_c_analog_in = 4'h0;
  logic [7:0]  port_b_pull_on_out, port_b_pull_down_out, port_b_slew_on_out;
  logic [7:0]  port_b_drive_high_out, pin_b, sh [8] = '{default: 8'h0};
  logic [3:0]  port_c_pull_on_out, port_c_pull_down_out, port_c_slew_on_out;
  logic [3:0]  port_c_drive_high_out;
  logic [47:0] pq [$];
  logic [31:0] rq [$];
  integer      seed = 32'h885b;
  int          bad_count = 0, cmp_count = 0, cyc = 0;
  wire logic [47:0] pads_w = {port_b_pull_on_out, port_b_pull_down_out, port_b_slew_on_out,
    port_b_drive_high_out, port_c_pull_on_out, port_c_pull_down_out, port_c_slew_on_out,
    port_c_drive_high_out};

  ppc_top ppc_top_i (.*);
  ppc_pad_model ppc_pad_model_i (.clk_in(clk_in), .pull_on_in(port_b_pull_on_out),
    .pull_down_in(port_b_pull_down_out), .pin_out(pin_b));

  always #5 clk_in = ~clk_in;

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("mismatches %0d compares %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] dat,
    input logic [3:0] be);
    @(posedge clk_in);
    avs_read_in <= !wr;
    avs_write_in <= wr;
    avs_address_in <= adr;
    avs_writedata_in <= dat;
    avs_byteenable_in <= be;
    do
      @(posedge clk_in);
    while (avs_waitrequest_out !== 1'b0);
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  function automatic logic [47:0] pads();
    logic [7:0] ob, pb;
    logic [3:0] oc, pc;
    ob = port_b_direction_in | port_b_periph_oe_in;
    oc = port_c_direction_in | port_c_periph_oe_in;
    pb = sh[0] & ~ob & ~port_b_analog_in;
    pc = sh[4][3:0] & ~oc & ~port_c_analog_in;
    return {pb, sh[1] & pb, sh[2] & ob, sh[3], pc, sh[5][3:0] & pc, sh[6][3:0] & oc, sh[7][3:0]};
  endfunction

  always @(posedge clk_in)
  begin
    logic [47:0] p;
    if (avs_read_in && avs_waitrequest_out === 1'b0)
      chk({16'h0, avs_readdata_out}, {16'h0, rq.pop_front()});
    if (snap)
    begin
      p = pq.pop_front();
      chk(pads_w, p);
      chk({40'h0, pin_b & p[47:40]}, {40'h0, p[47:40] & ~p[39:32]});
    end
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      test_done();
    end
  end

  initial
  begin
    logic [31:0] d, w, e;
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      rq.push_back(32'h0);
      bus(1'b0, i[3:0], 32'h0, 4'h0);
    end
    // inputs overlap on purpose so pulls are sometimes left enabled
    for (int n = 0; n < 80; n++)
    begin
      d = $random(seed);
      port_b_direction_in <= d[7:0];
      port_b_periph_oe_in <= d[15:8] & d[23:16];
      port_b_analog_in <= d[31:24] & d[23:16];
      port_c_direction_in <= d[27:24];
      port_c_periph_oe_in <= d[11:8] & d[3:0];
      port_c_analog_in <= d[19:16] & d[3:0];
      d = $random(seed);
      w = $random(seed);
      e = $random(seed);
      if (d[3] == 1'b0 && e[0])
        sh[d[2:0]] = d[2] ? {4'h0, w[3:0]} : w[7:0];
      bus(1'b1, d[3:0], w, e[3:0]);
      rq.push_back(d[3] ? 32'h0 : {24'h0, sh[d[2:0]]});
      bus(1'b0, d[3:0], 32'h0, 4'h0);
      repeat (2) @(posedge clk_in);
      pq.push_back(pads());
      snap <= 1'b1;
      @(posedge clk_in);
      snap <= 1'b0;
    end
    // second reset after the random loop: every register must read back cleared
    srst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      sh[i] = 8'h00;
      rq.push_back(32'h0);
      bus(1'b0, i[3:0], 32'h0, 4'h0);
    end
    repeat (2) @(posedge clk_in);
    pq.push_back(pads());
    snap <= 1'b1;
    @(posedge clk_in);
    snap <= 1'b0;
    @(posedge clk_in);
    test_done();
  end
endmodule

bind ppc_top ppc_properties ppc_properties_i (.*);

// ===== hw/ppc_pin_ctrl.sv
// pad control decode for one port of up to eight pins
`timescale 1ns/100ps
module ppc_pin_ctrl
#(
  parameter int PINS = 8
)
(
  input  wire ppc_pkg::ppc_cfg_s cfg_in,
  input  wire logic [7:0]        dir_in,
  input  wire logic [7:0]        periph_oe_in,
  input  wire logic [7:0]        analog_in,
  output ppc_pkg::ppc_pad_s      pad_out
);

  logic [7:0] is_out;
  logic [7:0] live;

  // pins above the port width are tied off
  assign live = 8'((9'h001 << PINS) - 9'h001);

  assign is_out = dir_in | periph_oe_in;

  always_comb
  begin
    // pull only when enabled, not driving and not analog
    pad_out.pull_on    = cfg_in.pull_en & ~is_out & ~analog_in & live;
    // polarity only meaningful with the pull on
    pad_out.pull_down  = cfg_in.pull_sel & pad_out.pull_on;
    pad_out.slew_on    = cfg_in.slew_en & is_out & live;
    pad_out.drive_high = cfg_in.drive_sel & live;
  end

endmodule

// ===== hw/ppc_top.sv
// port b and port c pad control registers with avalon-mm slave
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps
`include "ppc_consts.svh"
module ppc_top
(
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic [7:0]  port_b_direction_in,
  input  wire logic [3:0]  port_c_direction_in,
  input  wire logic [7:0]  port_b_periph_oe_in,
  input  wire logic [3:0]  port_c_periph_oe_in,
  input  wire logic [7:0]  port_b_analog_in,
  input  wire logic [3:0]  port_c_analog_in,
  output logic      [7:0]  port_b_pull_on_out,
  output logic      [7:0]  port_b_pull_down_out,
  output logic      [7:0]  port_b_slew_on_out,
  output logic      [7:0]  port_b_drive_high_out,
  output logic      [3:0]  port_c_pull_on_out,
  output logic      [3:0]  port_c_pull_down_out,
  output logic      [3:0]  port_c_slew_on_out,
  output logic      [3:0]  port_c_drive_high_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed
  {
    ppc_pkg::ppc_bus_e  bus;
    ppc_pkg::ppc_cfg_s  cfg_b;
    ppc_pkg::ppc_cfg_s  cfg_c;
    logic [31:0]        rdata;
    logic               wait_n;
    ppc_pkg::ppc_pad_s  pad_b;
    ppc_pkg::ppc_pad_s  pad_c;
  } ppc_state_s;

  ppc_state_s        st_ff;
  ppc_state_s        nxt_st;
  ppc_pkg::ppc_pad_s dec_b;
  ppc_pkg::ppc_pad_s dec_c;
  logic [7:0]        rd_byte;
  logic              mapped;
  logic              req;

  // ----------------------------------------------------------------
  // per-port pad decode
  // ----------------------------------------------------------------
  ppc_pin_ctrl #(.PINS(`PPC_PORT_B_PINS)) u_port_b
  (
    .cfg_in       (st_ff.cfg_b),
    .dir_in       (port_b_direction_in),
    .periph_oe_in (port_b_periph_oe_in),
    .analog_in    (port_b_analog_in),
    .pad_out      (dec_b)
  );

  ppc_pin_ctrl #(.PINS(`PPC_PORT_C_PINS)) u_port_c
  (
    .cfg_in       (st_ff.cfg_c),
    .dir_in       ({4'h0, port_c_direction_in}),
    .periph_oe_in ({4'h0, port_c_periph_oe_in}),
    .analog_in    ({4'h0, port_c_analog_in}),
    .pad_out      (dec_c)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  assign mapped = (avs_address_in < 4'(`PPC_NUM_REGS));
  assign req    = avs_read_in | avs_write_in;

  always_comb
  begin
    case (avs_address_in)
      `PPC_OFS_B_PULL_EN:   rd_byte = st_ff.cfg_b.pull_en;
      `PPC_OFS_B_PULL_SEL:  rd_byte = st_ff.cfg_b.pull_sel;
      `PPC_OFS_B_SLEW_EN:   rd_byte = st_ff.cfg_b.slew_en;
      `PPC_OFS_B_DRIVE_SEL: rd_byte = st_ff.cfg_b.drive_sel;
      `PPC_OFS_C_PULL_EN:   rd_byte = st_ff.cfg_c.pull_en;
      `PPC_OFS_C_PULL_SEL:  rd_byte = st_ff.cfg_c.pull_sel;
      `PPC_OFS_C_SLEW_EN:   rd_byte = st_ff.cfg_c.slew_en;
      `PPC_OFS_C_DRIVE_SEL: rd_byte = st_ff.cfg_c.drive_sel;
      default:              rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st       = st_ff;
    nxt_st.pad_b = dec_b;
    nxt_st.pad_c = dec_c;
    case (st_ff.bus)
      ppc_pkg::PPC_IDLE:
      begin
        nxt_st.wait_n = 1'b0;
        if (req)
        begin
          // registered answer costs one wait state but keeps outputs flopped
          nxt_st.bus    = ppc_pkg::PPC_ACK;
          nxt_st.wait_n = 1'b1;
          nxt_st.rdata  = mapped ? {24'h000000, rd_byte} : `PPC_UNMAPPED_DATA;
          if (avs_write_in && avs_byteenable_in[0])
          begin
            // only pad config is written; data and direction live elsewhere
            case (avs_address_in)
              `PPC_OFS_B_PULL_EN:   nxt_st.cfg_b.pull_en   = avs_writedata_in[7:0];
              `PPC_OFS_B_PULL_SEL:  nxt_st.cfg_b.pull_sel  = avs_writedata_in[7:0];
              `PPC_OFS_B_SLEW_EN:   nxt_st.cfg_b.slew_en   = avs_writedata_in[7:0];
              `PPC_OFS_B_DRIVE_SEL: nxt_st.cfg_b.drive_sel = avs_writedata_in[7:0];
              `PPC_OFS_C_PULL_EN:
                nxt_st.cfg_c.pull_en   = avs_writedata_in[7:0] & `PPC_PORT_C_MASK;
              `PPC_OFS_C_PULL_SEL:
                nxt_st.cfg_c.pull_sel  = avs_writedata_in[7:0] & `PPC_PORT_C_MASK;
              `PPC_OFS_C_SLEW_EN:
                nxt_st.cfg_c.slew_en   = avs_writedata_in[7:0] & `PPC_PORT_C_MASK;
              `PPC_OFS_C_DRIVE_SEL:
                nxt_st.cfg_c.drive_sel = avs_writedata_in[7:0] & `PPC_PORT_C_MASK;
              default:
                nxt_st.cfg_b = st_ff.cfg_b;
            endcase
          end
        end
      end
      ppc_pkg::PPC_ACK:
      begin
        // master releases after the ack edge
        nxt_st.wait_n = 1'b0;
        nxt_st.bus    = ppc_pkg::PPC_HOLD;
      end
      ppc_pkg::PPC_HOLD:
      begin
        nxt_st.wait_n = 1'b0;
        nxt_st.bus    = ppc_pkg::PPC_IDLE;
      end
      default:
      begin
        nxt_st.wait_n = 1'b0;
        nxt_st.bus    = ppc_pkg::PPC_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      st_ff.bus   <= ppc_pkg::PPC_IDLE;
      st_ff.cfg_b <= {4{`PPC_REG_RESET}};
      st_ff.cfg_c <= {4{`PPC_REG_RESET}};
      st_ff.rdata <= 32'h00000000;
      st_ff.wait_n <= 1'b0;
      st_ff.pad_b <= '0;
      st_ff.pad_c <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_readdata_out      = st_ff.rdata;
  assign avs_waitrequest_out   = ~st_ff.wait_n;
  assign port_b_pull_on_out    = st_ff.pad_b.pull_on;
  assign port_b_pull_down_out  = st_ff.pad_b.pull_down;
  assign port_b_slew_on_out    = st_ff.pad_b.slew_on;
  assign port_b_drive_high_out = st_ff.pad_b.drive_high;
  assign port_c_pull_on_out    = st_ff.pad_c.pull_on[3:0];
  assign port_c_pull_down_out  = st_ff.pad_c.pull_down[3:0];
  assign port_c_slew_on_out    = st_ff.pad_c.slew_on[3:0];
  assign port_c_drive_high_out = st_ff.pad_c.drive_high[3:0];

endmodule

// ===== inc/ppc_consts.svh
// offsets, field widths, reset values for the port pad control block
`ifndef PPC_CONSTS_SVH
`define PPC_CONSTS_SVH

`define PPC_OFS_B_PULL_EN   4'h0
`define PPC_OFS_B_PULL_SEL  4'h1
`define PPC_OFS_B_SLEW_EN   4'h2
`define PPC_OFS_B_DRIVE_SEL 4'h3
`define PPC_OFS_C_PULL_EN   4'h4
`define PPC_OFS_C_PULL_SEL  4'h5
`define PPC_OFS_C_SLEW_EN   4'h6
`define PPC_OFS_C_DRIVE_SEL 4'h7
`define PPC_NUM_REGS        8
`define PPC_PORT_B_PINS     8
`define PPC_PORT_C_PINS     4
`define PPC_PORT_C_MASK     8'h0f
`define PPC_REG_RESET       8'h00
`define PPC_UNMAPPED_DATA   32'h00000000

`endif

// ===== inc/ppc_pkg.sv
// types for the port pad control block
package ppc_pkg;

  typedef enum logic [2:0]
  {
    PPC_IDLE = 3'b001,
    PPC_ACK  = 3'b010,
    PPC_HOLD = 3'b100
  } ppc_bus_e;

  typedef struct packed
  {
    logic [7:0] pull_en;
    logic [7:0] pull_sel;
    logic [7:0] slew_en;
    logic [7:0] drive_sel;
  } ppc_cfg_s;

  typedef struct packed
  {
    logic [7:0] pull_on;
    logic [7:0] pull_down;
    logic [7:0] slew_on;
    logic [7:0] drive_high;
  } ppc_pad_s;

endpackage
